// >>> rsw_pkg.sv
// Constants, state encoding and timing counts for the reset supervisor watchdog
// Overview of operation
// [R1] A trigger drives the active-low reset output low for a pulse of the 200 ms stretch interval.
// [R2] Reset stays asserted the whole time the supply-low input or the manual clear input is active.
// [R3] Reset is held 200 ms after supply recovery, a watchdog expiry, or a manual input rising edge.
// [R4] A low level on the manual clear input asserts reset.
// [R5] Reset lasts while the manual input is low and a further 200 ms after it returns high.
// [R6] The active-high reset output is always the exact inverse of the active-low one.
// [R7] A service input that holds one level beyond the 1.60 s timeout triggers a reset.
// [R8] The watchdog timer is cleared whenever reset is asserted.
// [R9] Every service input edge clears the watchdog; the processor holds each level at least 50 ns.
// [R10] The watchdog is disabled while the watchdog-disable input is high.
// [R11] Manual low pulses of 100 ns or less are ignored; 1.0 us low always gives a reset.
// [R12] Each new supply-low indication restarts the stretch timer from zero.
// [R13] During reset the watchdog stays cleared and stopped, and it counts from reset release.
// [R14] Pin inputs pass a two-flop synchroniser, and the intervals come from a clock prescaler.
package rsw_pkg;
  // ----------------------------------------------------------------
  // Clock and prescaler
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ   = 40_000_000;
  localparam int CLK_MHZ       = CLK_FREQ_HZ / 1_000_000;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES   = TICK_US * CLK_MHZ;
  localparam int TICK_W        = 16;

  // ----------------------------------------------------------------
  // Interval timing
  // ----------------------------------------------------------------
  localparam int STRETCH_MS            = 200;
  localparam int SERVICE_TIMEOUT_MS    = 1600;
  localparam int SERVICE_TIMEOUT_MIN_MS = 1120;
  localparam int SERVICE_TIMEOUT_MAX_MS = 2400;
  localparam int MS_W                  = 11;
  localparam int SERVICE_PULSE_MIN_NS  = 50;

  // ----------------------------------------------------------------
  // Manual input glitch filter
  // ----------------------------------------------------------------
  localparam int MANUAL_IGNORE_NS     = 100;
  localparam int MANUAL_MIN_NS        = 1000;
  localparam int MANUAL_FILTER_CYCLES = (MANUAL_IGNORE_NS * CLK_MHZ) / 1000 + 1;
  localparam int FILT_W               = 3;

  // ----------------------------------------------------------------
  // Synchroniser layout {disable, toggle, manual_n, supply_low}
  // ----------------------------------------------------------------
  localparam int SYNC_W       = 4;
  localparam int SYNC_SUP     = 0;
  localparam int SYNC_MAN     = 1;
  localparam int SYNC_TOG     = 2;
  localparam int SYNC_DIS     = 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h3;

  // ----------------------------------------------------------------
  // Supervisor states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD    = 3'h1,
    ST_STRETCH = 3'h2,
    ST_RUN     = 3'h4
  } rsw_state_t;
endpackage : rsw_pkg

// >>> rsw_cond_if.sv
// Conditioned input bundle between the input stage and the supervisor
`timescale 1ns/10ps
interface rsw_cond_if;
  logic supply_low;
  logic manual_low;
  logic toggle_edge;
  logic wd_disable;

  modport src (
    output supply_low,
    output manual_low,
    output toggle_edge,
    output wd_disable
  );
  modport dst (
    input supply_low,
    input manual_low,
    input toggle_edge,
    input wd_disable
  );
endinterface : rsw_cond_if

// >>> rsw_input_cond.sv
// Input synchroniser, manual glitch filter and service edge detector
`timescale 1ns/10ps
module rsw_input_cond (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic supply_low_in,
  input  wire logic manual_clear_in_n,
  input  wire logic activity_toggle_in,
  input  wire logic watchdog_disable_in,
  rsw_cond_if.src   cond
);
  import rsw_pkg::*;

  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;
  logic              tog_prev_ff;
  logic [FILT_W-1:0] man_cnt_ff;
  logic              manual_low_ff;

  // ----------------------------------------------------------------
  // Two-flop synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end else begin
      meta_ff <= {watchdog_disable_in, activity_toggle_in,
                  manual_clear_in_n, supply_low_in};  // see [R14]
      sync_ff <= meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Service edge detector
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tog_prev_ff <= 1'b0;
    end else begin
      tog_prev_ff <= sync_ff[SYNC_TOG];
    end
  end

  // ----------------------------------------------------------------
  // Manual low filter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      man_cnt_ff    <= 3'h0;
      manual_low_ff <= 1'b0;
    end else if (sync_ff[SYNC_MAN]) begin
      man_cnt_ff    <= 3'h0;
      manual_low_ff <= 1'b0;
    end else if (man_cnt_ff == FILT_W'(MANUAL_FILTER_CYCLES - 1)) begin
      manual_low_ff <= 1'b1;  // see [R11]
    end else begin
      man_cnt_ff <= man_cnt_ff + 3'h1;
    end
  end

  assign cond.supply_low  = sync_ff[SYNC_SUP];
  assign cond.manual_low  = manual_low_ff;
  assign cond.toggle_edge = sync_ff[SYNC_TOG] ^ tog_prev_ff;  // see [R9]
  assign cond.wd_disable  = sync_ff[SYNC_DIS];
endmodule : rsw_input_cond

// >>> rsw_top.sv
// Reset supervisor with stretch timer and service watchdog
`timescale 1ns/10ps
module rsw_top #(
  parameter int TICK_CYCLES_P = rsw_pkg::TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic supply_low_in,
  input  wire logic manual_clear_in_n,
  input  wire logic activity_toggle_in,
  input  wire logic watchdog_disable_in,
  output wire logic reset_out_n,
  output wire logic reset_out
);
  import rsw_pkg::*;

  rsw_cond_if cond_if ();

  rsw_state_t        state_ff;
  rsw_state_t        nxt_state;
  logic [TICK_W-1:0] tick_cnt_ff;
  logic [MS_W-1:0]   stretch_cnt_ff;
  logic [MS_W-1:0]   wd_cnt_ff;
  logic              reset_n_ff;
  logic              cause;
  logic              tick;
  logic              in_run;
  logic              wd_service;
  logic              wd_expire;
  logic              stretch_done;
  logic              tick_restart;

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  rsw_input_cond u_cond (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .supply_low_in       (supply_low_in),
    .manual_clear_in_n   (manual_clear_in_n),
    .activity_toggle_in  (activity_toggle_in),
    .watchdog_disable_in (watchdog_disable_in),
    .cond                (cond_if.src)
  );

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign cause        = cond_if.supply_low | cond_if.manual_low;  // see [R2] see [R4]
  assign in_run       = (state_ff == ST_RUN);
  assign tick         = (tick_cnt_ff == TICK_W'(TICK_CYCLES_P - 1));
  assign wd_service   = cond_if.toggle_edge | cond_if.wd_disable;
  assign wd_expire    = in_run & ~cause & ~wd_service & tick
                      & (wd_cnt_ff == MS_W'(SERVICE_TIMEOUT_MS - 1));  // see [R7] see [R10]
  assign stretch_done = tick & (stretch_cnt_ff == MS_W'(STRETCH_MS - 1));
  assign tick_restart = cause | wd_expire | (in_run & wd_service);

  // ----------------------------------------------------------------
  // Prescaler, one tick per millisecond
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tick_cnt_ff <= 16'h0000;
    end else if (tick_restart || tick) begin
      tick_cnt_ff <= 16'h0000;  // see [R14]
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Supervisor state machine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_HOLD: begin
        if (!cause) begin
          nxt_state = ST_STRETCH;  // see [R3] see [R5]
        end
      end
      ST_STRETCH: begin
        if (cause) begin
          nxt_state = ST_HOLD;
        end else if (stretch_done) begin
          nxt_state = ST_RUN;  // see [R1]
        end
      end
      ST_RUN: begin
        if (cause) begin
          nxt_state = ST_HOLD;
        end else if (wd_expire) begin
          nxt_state = ST_STRETCH;  // see [R3]
        end
      end
      default: begin
        nxt_state = ST_STRETCH;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= ST_STRETCH;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Stretch timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stretch_cnt_ff <= 11'h000;
    end else if (cause || state_ff != ST_STRETCH) begin
      stretch_cnt_ff <= 11'h000;  // see [R12]
    end else if (tick) begin
      stretch_cnt_ff <= stretch_cnt_ff + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Service watchdog timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wd_cnt_ff <= 11'h000;
    end else if (!in_run || cause) begin
      wd_cnt_ff <= 11'h000;  // see [R8] see [R13]
    end else if (wd_service || wd_expire) begin
      wd_cnt_ff <= 11'h000;  // see [R9] see [R10]
    end else if (tick) begin
      wd_cnt_ff <= wd_cnt_ff + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Reset outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reset_n_ff <= 1'b0;
    end else begin
      reset_n_ff <= (nxt_state == ST_RUN);  // see [R1] see [R2]
    end
  end

  assign reset_out_n = reset_n_ff;
  assign reset_out   = ~reset_n_ff;  // see [R6]
endmodule : rsw_top

// >>> rsw_checker.sv
// Port-level assertions for the reset supervisor
`timescale 1ns/10ps
module rsw_checker import rsw_pkg::*; #(
  parameter int TICK_CYCLES_P = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic supply_low_in,
  input wire logic manual_clear_in_n,
  input wire logic activity_toggle_in,
  input wire logic watchdog_disable_in,
  input wire logic reset_out_n,
  input wire logic reset_out
);
  localparam int STR_C = STRETCH_MS * TICK_CYCLES_P;
  localparam int WD_C  = SERVICE_TIMEOUT_MS * TICK_CYCLES_P;
  int   str_ff;
  int   idle_ff;
  int   quiet_ff;
  logic tog_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Cycles of reset low with no cause active
  always_ff @(posedge core_clk) begin
    if (!rst_n || supply_low_in || !manual_clear_in_n || reset_out_n) str_ff <= 0;
    else str_ff <= str_ff + 1;
  end
  // Cycles since the last service edge while out of reset
  always_ff @(posedge core_clk) begin
    tog_ff <= activity_toggle_in;
    if (!rst_n || !reset_out_n || watchdog_disable_in || activity_toggle_in != tog_ff)
      idle_ff <= 0;
    else idle_ff <= idle_ff + 1;
    if (!rst_n || supply_low_in || !manual_clear_in_n) quiet_ff <= 0;
    else if (quiet_ff < 15) quiet_ff <= quiet_ff + 1;
  end
  property p_inverse; reset_out == !reset_out_n; endproperty
  property p_supply; supply_low_in [*5] |-> !reset_out_n; endproperty
  property p_sync;
    reset_out_n && $rose(supply_low_in) |=> reset_out_n ##[1:4] !reset_out_n;
  endproperty
  property p_manual; !manual_clear_in_n [*8] |-> ##[1:3] !reset_out_n; endproperty
  property p_glitch;
    reset_out_n && quiet_ff == 15 && $fell(manual_clear_in_n) ##1 !manual_clear_in_n
      ##1 manual_clear_in_n |-> reset_out_n [*8];
  endproperty
  property p_stretch; $rose(reset_out_n) |-> str_ff >= STR_C-2 && str_ff <= STR_C+8; endproperty
  property p_wd_fire; reset_out_n |-> idle_ff <= WD_C+8; endproperty
  property p_no_early;
    reset_out_n && quiet_ff == 15 && idle_ff < WD_C-4 |=> reset_out_n;
  endproperty
  a_inverse: assert property (p_inverse) else $error("outputs not inverse");
  a_supply: assert property (p_supply) else $error("supply low without reset");
  a_sync: assert property (p_sync) else $error("supply latency wrong");
  a_manual: assert property (p_manual) else $error("manual low without reset");
  a_glitch: assert property (p_glitch) else $error("short pulse gave reset");
  a_stretch: assert property (p_stretch) else $error("stretch length wrong");
  a_wd_fire: assert property (p_wd_fire) else $error("watchdog did not fire");
  a_no_early: assert property (p_no_early) else $error("early reset");
  c_stretch: cover property ($rose(reset_out_n));
  c_fire: cover property (reset_out_n && idle_ff > WD_C-8 ##1 !reset_out_n);
  c_glitch: cover property ($rose(manual_clear_in_n) && reset_out_n);
endmodule : rsw_checker

// >>> rsw_proc_model.sv
// Processor model that services the watchdog input
`timescale 1ns/10ps
module rsw_proc_model (
  input  wire logic        core_clk,
  input  wire logic        reset_out_n,
  input  wire logic        svc_en,
  input  wire logic [15:0] svc_period,
  output logic             activity_toggle_in
);
  logic [15:0] cnt_ff = 16'h0000;
  initial activity_toggle_in = 1'b0;
  // Each level held svc_period+1 cycles, far above the minimum
  always @(negedge core_clk) begin
    if (svc_en && reset_out_n) begin
      cnt_ff <= cnt_ff + 16'h0001;
      if (cnt_ff >= svc_period) begin
        cnt_ff <= 16'h0000;
        activity_toggle_in <= ~activity_toggle_in;
      end
    end
  end
endmodule : rsw_proc_model

// >>> rsw_top_tb.sv
// Self-checking testbench for the reset supervisor
`timescale 1ns/10ps
module rsw_top_tb;
  import rsw_pkg::*;
  localparam int TP    = 8;
  localparam int STR_C = STRETCH_MS * TP;
  localparam int WD_C  = SERVICE_TIMEOUT_MS * TP;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        supply_low_in = 1'b0;
  logic        manual_clear_in_n = 1'b1;
  logic        watchdog_disable_in = 1'b0;
  logic        svc_en = 1'b0;
  logic [15:0] svc_period = 16'h0032;
  wire logic   activity_toggle_in;
  wire logic   reset_out_n;
  wire logic   reset_out;
  int          fail_count = 0;
  int          n_tests = 0;
  int          n;
  always #12.5 core_clk = ~core_clk;
  rsw_top #(.TICK_CYCLES_P(TP)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .supply_low_in(supply_low_in), .manual_clear_in_n(manual_clear_in_n),
    .activity_toggle_in(activity_toggle_in), .watchdog_disable_in(watchdog_disable_in),
    .reset_out_n(reset_out_n), .reset_out(reset_out));
  rsw_proc_model u_proc (.core_clk(core_clk), .reset_out_n(reset_out_n), .svc_en(svc_en),
    .svc_period(svc_period), .activity_toggle_in(activity_toggle_in));
  task automatic step(input int c);
    repeat (c) @(negedge core_clk);
  endtask : step
  task automatic chk(input logic e, input string m);
    n_tests++;
    if (reset_out_n !== e || reset_out !== ~e) begin
      fail_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic chk_rng(input int v, input int lo, input int hi, input string m);
    n_tests++;
    if (v < lo || v > hi) begin
      fail_count++;
      $display("Error at %0t: %s %0d", $time, m, v);
    end
  endtask : chk_rng
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic t_supply;
    supply_low_in = 1'b1; step(20); chk(1'b0, "supply hold");
    supply_low_in = 1'b0; step(STR_C-100); chk(1'b0, "supply stretch");
    supply_low_in = 1'b1; step(5); supply_low_in = 1'b0;
    step(STR_C-30); chk(1'b0, "stretch restart");
    step(50); chk(1'b1, "supply release");
  endtask : t_supply
  task automatic t_manual;
    manual_clear_in_n = 1'b0; step(40); chk(1'b0, "manual low");
    step(STR_C); chk(1'b0, "manual held");
    manual_clear_in_n = 1'b1; step(STR_C-30); chk(1'b0, "manual stretch");
    step(50); chk(1'b1, "manual release");
    manual_clear_in_n = 1'b0; step(2); manual_clear_in_n = 1'b1;
    step(20); chk(1'b1, "glitch ignored");
    manual_clear_in_n = 1'b0; step(40); manual_clear_in_n = 1'b1;
    step(5); chk(1'b0, "1 us pulse");
    step(STR_C+30); chk(1'b1, "pulse release");
  endtask : t_manual
  task automatic t_service;
    svc_en = 1'b1;
    repeat (20) begin step(100); chk(1'b1, "fast service"); end
    svc_period = 16'h2ee0;
    repeat (2) begin step(12000); chk(1'b1, "slow service"); end
  endtask : t_service
  task automatic t_timeout;
    svc_period = 16'h0032;
    @(activity_toggle_in); step(1); svc_en = 1'b0;
    n = 0;
    while (reset_out_n === 1'b1 && n < WD_C+100) begin step(1); n++; end
    chk_rng(n, WD_C-10, WD_C+10, "timeout cycles");
    step(STR_C+30); chk(1'b1, "expiry stretch");
    step(WD_C-200); chk(1'b1, "timer cleared in reset");
    watchdog_disable_in = 1'b1; step(WD_C+500); chk(1'b1, "watchdog disabled");
    watchdog_disable_in = 1'b0;
  endtask : t_timeout
  initial begin
    step(3);
    rst_n = 1'b1;
    step(10); chk(1'b0, "power-up low");
    step(STR_C-40); chk(1'b0, "power-up stretch");
    step(60); chk(1'b1, "power-up release");
    t_supply();
    t_manual();
    t_service();
    t_timeout();
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end
endmodule : rsw_top_tb
bind rsw_top rsw_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (.core_clk(core_clk),
  .rst_n(rst_n), .supply_low_in(supply_low_in), .manual_clear_in_n(manual_clear_in_n),
  .activity_toggle_in(activity_toggle_in), .watchdog_disable_in(watchdog_disable_in),
  .reset_out_n(reset_out_n), .reset_out(reset_out));
